// ### verilog/uart_port_regs.svh
// Purpose: constants of the serial host register port
// Assumes: included by the port and its package users
// Notes: register addresses are 7-bit, byte bit 0 is the mode
`ifndef UART_PORT_REGS_SVH
`define UART_PORT_REGS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define SPEED_ADDR 7'h7E
`define STATUS_ADDR 7'h7F
`define SPEED_RESET 8'h7A
`define MODE_BIT 0
`define EXP_HI 7
`define EXP_LO 5
`define MANT_HI 4
`define MANT_LO 0
`define ST_OVERRUN 0
`define ST_FRAMING 1
`define ST_TRIGGER 2

// ----------------------------------------
// bit timing
// ----------------------------------------
`define REF_KHZ 25'd27120
`define SYS_KHZ 25'd100000
`define OVERSAMPLE 25'd16
`define LIMIT_UNIT (`SYS_KHZ / `OVERSAMPLE)
`define MANT_ONE 12'h001
`define MANT_BIAS 12'h021
`define EXP_ONE 3'h1
`define MIN_DIV 12'h016
`define SUB_MID 4'h7
`define SUB_LAST 4'hF
`define BIT_LAST 3'h7
`define FIFO_DEPTH 8

`endif

// ### verilog/uart_port_pkg.sv
// Purpose: types shared by the serial host register port
// Assumes: constants come from uart_port_regs.svh
// Notes: line state codes are gray along the usual path; command codes only along the write path
package uart_port_pkg;

  // ----------------------------------------
  // state machines
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    LINE_IDLE = 2'h0,
    LINE_START = 2'h1,
    LINE_DATA = 2'h3,
    LINE_STOP = 2'h2
  } line_state_t;

  typedef enum logic [1:0]
  {
    CMD_ADDR = 2'h0,
    CMD_DATA = 2'h1,
    CMD_FETCH = 2'h3
  } cmd_state_t;

  // ----------------------------------------
  // request to the register core
  // ----------------------------------------
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : uart_port_pkg

// ### verilog/byte_fifo.sv
// Purpose: small flop-based first-in first-out buffer
// Assumes: one clock, asynchronous active-low reset
// Notes: in_ready low when full, out_valid low when empty
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // pointers wrap only for a power-of-two depth
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : byte_fifo

// ### verilog/uart_host_register_port.sv
// Purpose: serial host port giving register read and write access
// Assumes: clk_sys 100 MHz, rate scaled from a 27.12 MHz reference
// Notes: core_rdata must be valid while core_req.rd is high
`include "uart_port_regs.svh"

module uart_host_register_port (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic read_trigger_pin,
  output uart_port_pkg::reg_req_t core_req,
  input wire logic [7:0] core_rdata
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // bit period in reference cycles
  function automatic logic [11:0] bit_divisor(input logic [7:0] speed);
    logic [2:0] speed_exponent;
    logic [11:0] speed_mantissa;
    logic [11:0] div;
    speed_exponent = speed[`EXP_HI:`EXP_LO];
    speed_mantissa = {7'h00, speed[`MANT_HI:`MANT_LO]};
    if (speed_exponent == 3'h0)
      div = speed_mantissa + `MANT_ONE;
    else
      div = (speed_mantissa + `MANT_BIAS)
        << (speed_exponent - `EXP_ONE);
    // settings faster than the ceiling are clamped to it
    if (div < `MIN_DIV)
      div = `MIN_DIV;
    return div;
  endfunction : bit_divisor

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic rx_meta;
  logic rx_s;
  logic trig_meta;
  logic trig_s;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_meta <= 1'b1;
      rx_s <= 1'b1;
      trig_meta <= 1'b0;
      trig_s <= 1'b0;
    end
    else
    begin
      rx_meta <= rx_pin;
      rx_s <= rx_meta;
      trig_meta <= read_trigger_pin;
      trig_s <= trig_meta;
    end
  end

  // ----------------------------------------
  // speed register and rate generator
  // ----------------------------------------
  logic [7:0] serial_speed;
  logic [7:0] active_speed;
  logic [24:0] acc;
  uart_port_pkg::line_state_t rx_state;
  uart_port_pkg::line_state_t tx_state;

  // a new rate takes effect only between characters
  wire line_quiet = rx_state == uart_port_pkg::LINE_IDLE
    && tx_state == uart_port_pkg::LINE_IDLE;
  wire [24:0] sub_limit =
    {13'h0000, bit_divisor(active_speed)} * `LIMIT_UNIT;
  // phase accumulator keeps the reference ratio exact
  wire [24:0] acc_sum = acc + `REF_KHZ;
  wire sub_tick = acc_sum >= sub_limit;
  wire [24:0] next_acc = sub_tick ? acc_sum - sub_limit : acc_sum;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc <= '0;
      active_speed <= `SPEED_RESET;
    end
    else
    begin
      acc <= next_acc;
      if (line_quiet)
        active_speed <= serial_speed;
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  logic [3:0] rx_sub;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  uart_port_pkg::line_state_t next_rx_state;
  logic [3:0] next_rx_sub;
  logic [2:0] next_rx_bit;
  logic [7:0] next_rx_shift;

  wire rx_sub_last = rx_sub == `SUB_LAST;
  wire rx_stop_end = sub_tick && rx_sub_last
    && rx_state == uart_port_pkg::LINE_STOP;
  wire rx_push = rx_stop_end && rx_s;
  wire rx_frame_err = rx_stop_end && !rx_s;

  always_comb
  begin
    next_rx_state = rx_state;
    next_rx_sub = rx_sub;
    next_rx_bit = rx_bit;
    next_rx_shift = rx_shift;
    if (sub_tick)
    begin
      next_rx_sub = rx_sub + 4'h1;
      case (rx_state)
        uart_port_pkg::LINE_IDLE:
        begin
          next_rx_sub = 4'h0;
          if (!rx_s)
            next_rx_state = uart_port_pkg::LINE_START;
        end
        uart_port_pkg::LINE_START:
        begin
          // a glitch shorter than half a bit is dropped
          if (rx_sub == `SUB_MID)
          begin
            next_rx_sub = 4'h0;
            next_rx_bit = 3'h0;
            next_rx_state = rx_s ? uart_port_pkg::LINE_IDLE
              : uart_port_pkg::LINE_DATA;
          end
        end
        uart_port_pkg::LINE_DATA:
        begin
          if (rx_sub_last)
          begin
            next_rx_shift = {rx_s, rx_shift[7:1]};
            next_rx_bit = rx_bit + 3'h1;
            if (rx_bit == `BIT_LAST)
              next_rx_state = uart_port_pkg::LINE_STOP;
          end
        end
        default:
        begin
          if (rx_sub_last)
            next_rx_state = uart_port_pkg::LINE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_state <= uart_port_pkg::LINE_IDLE;
      rx_sub <= 4'h0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
    end
    else
    begin
      rx_state <= next_rx_state;
      rx_sub <= next_rx_sub;
      rx_bit <= next_rx_bit;
      rx_shift <= next_rx_shift;
    end
  end

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  logic fifo_in_ready;
  logic fifo_valid;
  logic fifo_ready;
  logic [7:0] fifo_byte;

  // the line cannot be stalled, so a full buffer loses the byte
  wire rx_overrun = rx_push && !fifo_in_ready;

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(`FIFO_DEPTH)
  ) rx_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(rx_push),
    .in_ready(fifo_in_ready),
    .in_data(next_rx_shift),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_byte)
  );

  // ----------------------------------------
  // command decoder
  // ----------------------------------------
  uart_port_pkg::cmd_state_t cmd_state;
  logic [6:0] cmd_addr;
  logic [1:0] sticky;

  wire tx_free = tx_state == uart_port_pkg::LINE_IDLE;
  wire in_addr = cmd_state == uart_port_pkg::CMD_ADDR;
  wire in_data = cmd_state == uart_port_pkg::CMD_DATA;
  wire in_fetch = cmd_state == uart_port_pkg::CMD_FETCH;
  // address bytes wait for a free transmitter; data never waits
  assign fifo_ready = (in_addr && tx_free) || in_data;
  wire take = fifo_valid && fifo_ready;
  wire take_addr = take && in_addr;
  wire is_read = fifo_byte[`MODE_BIT];
  wire [6:0] byte_addr = fifo_byte[7:1];
  wire start_read = take_addr && is_read && trig_s;
  wire start_write = take_addr && !is_read;
  wire take_data = take && in_data;

  wire hit_speed = cmd_addr == `SPEED_ADDR;
  wire hit_status = cmd_addr == `STATUS_ADDR;
  wire hit_local = hit_speed || hit_status;
  wire [7:0] status_word = {5'h00, trig_s, sticky};
  wire [7:0] read_value = hit_speed ? serial_speed
    : hit_status ? status_word : core_rdata;
  wire clear_status = in_fetch && hit_status;

  uart_port_pkg::cmd_state_t next_cmd_state;

  always_comb
  begin
    next_cmd_state = cmd_state;
    case (cmd_state)
      uart_port_pkg::CMD_ADDR:
      begin
        if (start_read)
          next_cmd_state = uart_port_pkg::CMD_FETCH;
        else if (start_write)
          next_cmd_state = uart_port_pkg::CMD_DATA;
      end
      uart_port_pkg::CMD_DATA:
      begin
        if (take_data)
          next_cmd_state = uart_port_pkg::CMD_ADDR;
      end
      default:
        next_cmd_state = uart_port_pkg::CMD_ADDR;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_state <= uart_port_pkg::CMD_ADDR;
      cmd_addr <= 7'h00;
    end
    else
    begin
      cmd_state <= next_cmd_state;
      if (take_addr)
        cmd_addr <= byte_addr;
    end
  end

  // ----------------------------------------
  // registers and core strobes
  // ----------------------------------------
  uart_port_pkg::reg_req_t next_req;

  assign next_req.wr = take_data && !hit_local;
  assign next_req.rd = start_read
    && !(byte_addr == `SPEED_ADDR || byte_addr == `STATUS_ADDR);
  // the core sees address and data move only with a strobe
  assign next_req.addr = next_req.rd ? byte_addr
    : next_req.wr ? cmd_addr : core_req.addr;
  assign next_req.wdata = next_req.wr ? fifo_byte : core_req.wdata;

  // an event in the clearing cycle survives the clear
  wire [1:0] sticky_set = {rx_frame_err, rx_overrun};
  wire [1:0] next_sticky = (clear_status ? 2'b00 : sticky) | sticky_set;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      core_req <= '0;
      serial_speed <= `SPEED_RESET;
      sticky <= 2'b00;
    end
    else
    begin
      core_req <= next_req;
      sticky <= next_sticky;
      if (take_data && hit_speed)
        serial_speed <= fifo_byte;
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  logic [3:0] tx_sub;
  logic [2:0] tx_bit;
  logic [7:0] tx_shift;
  uart_port_pkg::line_state_t next_tx_state;
  logic [3:0] next_tx_sub;
  logic [2:0] next_tx_bit;
  logic [7:0] next_tx_shift;

  // reply in the fetch cycle, echo as a write address is taken
  wire tx_go = in_fetch || start_write;
  wire [7:0] tx_load = in_fetch ? read_value : fifo_byte;
  wire tx_sub_last = tx_sub == `SUB_LAST;
  wire next_tx_line = next_tx_state == uart_port_pkg::LINE_START
    ? 1'b0 : next_tx_state == uart_port_pkg::LINE_DATA
    ? next_tx_shift[0] : 1'b1;

  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_sub = tx_sub;
    next_tx_bit = tx_bit;
    next_tx_shift = tx_shift;
    case (tx_state)
      uart_port_pkg::LINE_IDLE:
      begin
        next_tx_sub = 4'h0;
        next_tx_bit = 3'h0;
        if (tx_go)
        begin
          next_tx_shift = tx_load;
          // first tick only aligns, so the start bit is never short
          next_tx_sub = `SUB_LAST;
          next_tx_bit = 3'h1;
          next_tx_state = uart_port_pkg::LINE_START;
        end
      end
      uart_port_pkg::LINE_START:
      begin
        if (sub_tick)
        begin
          next_tx_sub = tx_sub + 4'h1;
          if (tx_sub_last)
          begin
            if (tx_bit != 3'h0)
              next_tx_bit = 3'h0;
            else
              next_tx_state = uart_port_pkg::LINE_DATA;
          end
        end
      end
      uart_port_pkg::LINE_DATA:
      begin
        if (sub_tick)
        begin
          next_tx_sub = tx_sub + 4'h1;
          if (tx_sub_last)
          begin
            next_tx_shift = {1'b0, tx_shift[7:1]};
            next_tx_bit = tx_bit + 3'h1;
            if (tx_bit == `BIT_LAST)
              next_tx_state = uart_port_pkg::LINE_STOP;
          end
        end
      end
      default:
      begin
        if (sub_tick)
        begin
          next_tx_sub = tx_sub + 4'h1;
          if (tx_sub_last)
            next_tx_state = uart_port_pkg::LINE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_state <= uart_port_pkg::LINE_IDLE;
      tx_sub <= 4'h0;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
      tx_pin <= 1'b1;
    end
    else
    begin
      tx_state <= next_tx_state;
      tx_sub <= next_tx_sub;
      tx_bit <= next_tx_bit;
      tx_shift <= next_tx_shift;
      tx_pin <= next_tx_line;
    end
  end

endmodule : uart_host_register_port

// ### verif/uart_port_properties.sv
// Purpose: port-level checks of the serial register port
// Assumes: one clock domain, bound to the port's top module
// Notes: bit width bound uses the fastest divisor, 22
module uart_port_checker (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic rx_pin,
  input wire logic tx_pin,
  input wire logic read_trigger_pin,
  input wire uart_port_pkg::reg_req_t core_req,
  input wire logic [7:0] core_rdata
);
  logic prev_tx;
  logic [11:0] run;

  // saturating count of cycles the line has held its level
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prev_tx <= 1'b1;
      run <= 12'hFFF;
    end
    else
    begin
      prev_tx <= tx_pin;
      run <= (tx_pin != prev_tx) ? 12'h001 : run + {11'h0, run != 12'hFFF};
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  a_reset_idle: assert property (
    $rose(arst_n) |-> tx_pin && core_req == '0)
    else $error("port not idle after reset");
  a_no_both: assert property (
    !(core_req.wr && core_req.rd))
    else $error("read and write strobes together");
  a_one_strobe: assert property (
    (core_req.wr || core_req.rd) |=> !(core_req.wr || core_req.rd) [*8])
    else $error("strobes too close");
  a_read_trigger: assert property (
    core_req.rd |-> $past(read_trigger_pin, 3))
    else $error("read strobe without trigger");
  a_reply_soon: assert property (
    core_req.rd |-> ##[1:80] !tx_pin)
    else $error("no reply start after read");
  a_bit_width: assert property (
    (tx_pin != prev_tx) |-> run >= 12'd78)
    else $error("tx bit shorter than fastest rate");
  a_addr_hold: assert property (
    $changed(core_req.addr) |-> core_req.wr || core_req.rd)
    else $error("address moved without strobe");
  a_data_hold: assert property (
    $changed(core_req.wdata) |-> core_req.wr)
    else $error("write data moved without write");
endmodule : uart_port_checker

bind uart_host_register_port uart_port_checker chk (
  .clk_sys(clk_sys),
  .arst_n(arst_n),
  .rx_pin(rx_pin),
  .tx_pin(tx_pin),
  .read_trigger_pin(read_trigger_pin),
  .core_req(core_req),
  .core_rdata(core_rdata)
);

// ### verif/host_uart_model.sv
// Purpose: host side of the serial register link
// Assumes: tb calls send and sets bit_clk between transfers
// Notes: bit time counted in whole system clocks
module host_uart_model (
  input wire logic clk_sys,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;

  int bit_clk = 868;
  logic [8:0] last;
  time t_rise;
  time frame_ns;
  event got_ev;

  initial line_out = 1'b1;

  // low start, data lsb first, high stop, no parity
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk_sys);
      line_out = fr[i];
      repeat (bit_clk - 1) @(negedge clk_sys);
    end
  endtask : send

  always @(posedge line_in) t_rise = $time;

  // last rise before the stop sample gives the frame length
  always
  begin
    time t0;
    @(negedge line_in);
    t0 = $time;
    repeat (bit_clk / 2) @(posedge clk_sys);
    for (int i = 0; i < 9; i++)
    begin
      repeat (bit_clk) @(posedge clk_sys);
      last[i] = line_in;
    end
    frame_ns = t_rise - t0;
    -> got_ev;
  end
endmodule : host_uart_model

// ### verif/tb.sv
// Purpose: self-checking bench of the serial register port
// Assumes: host model drives the link, tb plays the core
// Notes: expected results wait in queues until they show up
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic read_trigger_pin = 1'b0;
  logic rx_pin;
  logic tx_pin;
  uart_port_pkg::reg_req_t core_req;
  logic [7:0] core_rdata;
  logic [16:0] exp_tx[$];
  logic [16:0] exp_req[$];
  logic [7:0] last_wd = 8'h00;
  logic [6:0] ra;
  logic [7:0] rd8;
  int err_count = 0;
  int total_checks = 0;
  int seed;

  always #5 clk_sys = ~clk_sys;
  assign core_rdata = {1'b0, core_req.addr ^ 7'h35};

  uart_host_register_port dut (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .rx_pin(rx_pin),
    .tx_pin(tx_pin),
    .read_trigger_pin(read_trigger_pin),
    .core_req(core_req),
    .core_rdata(core_rdata)
  );

  host_uart_model host (
    .clk_sys(clk_sys),
    .line_in(tx_pin),
    .line_out(rx_pin)
  );

  function automatic logic [16:0] pop(ref logic [16:0] q[$]);
    pop = 'x;
    if (q.size() != 0)
      pop = q.pop_front();
  endfunction : pop

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  always @(negedge clk_sys)
    if (core_req.wr || core_req.rd)
      check(core_req, pop(exp_req));

  always @(host.got_ev)
    check({8'h00, host.last}, pop(exp_tx));

  // d is the write data, or the reply of a local register
  task automatic access(input logic [6:0] a, input logic rd,
                        input logic [7:0] d);
    logic [7:0] ab;
    int n;
    ab = {a, rd};
    if (rd && read_trigger_pin)
    begin
      exp_tx.push_back({8'h00, 1'b1, (a < 7'h7E) ? {1'b0, a ^ 7'h35} : d});
      if (a < 7'h7E)
        exp_req.push_back({1'b0, 1'b1, a, last_wd});
    end
    if (!rd)
      exp_tx.push_back({8'h00, 1'b1, ab});
    if (!rd && a < 7'h7E)
    begin
      exp_req.push_back({1'b1, 1'b0, a, d});
      last_wd = d;
    end
    host.send(ab);
    if (!rd)
      host.send(d);
    n = 0;
    while ((exp_tx.size() + exp_req.size()) != 0 && n < 30000)
    begin
      @(posedge clk_sys);
      n++;
    end
    repeat (host.bit_clk * 2) @(posedge clk_sys);
  endtask : access

  // nine bit periods from start fall to the rise into stop
  task automatic rate(input real kbps);
    real per;
    per = host.frame_ns / 9.0;
    check(17'(per <= 1.015e6 / kbps + 2.0 && per >= 0.985e6 / kbps - 2.0),
          17'h1);
  endtask : rate

  task automatic results;
    check(17'(exp_tx.size() + exp_req.size()), 17'h0);
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  initial
  begin
    seed = $urandom(32'h7AD5);
    repeat (3) @(negedge clk_sys);
    arst_n = 1'b1;
    read_trigger_pin = 1'b1;
    access(7'h12, 1'b1, 8'h00);
    rate(115.2);
    access(7'h7E, 1'b0, 8'h1C);
    host.bit_clk = 108;
    access(7'h7E, 1'b1, 8'h1C);
    rate(921.6);
    access(7'h7E, 1'b0, 8'h15);
    host.bit_clk = 81;
    access(7'h7E, 1'b1, 8'h15);
    rate(1228.8);
    $display("test speed done");
    for (int i = 0; i < 6; i++)
    begin
      ra = 7'($urandom_range(0, 125));
      rd8 = 8'($urandom);
      access(ra, 1'b0, rd8);
      access(ra, 1'b1, 8'h00);
    end
    $display("test access done");
    @(negedge clk_sys);
    read_trigger_pin = 1'b0;
    access(7'h33, 1'b1, 8'h00);
    @(negedge clk_sys);
    read_trigger_pin = 1'b1;
    access(7'h7F, 1'b1, 8'h04);
    $display("test trigger done");
    results;
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    results;
  end
endmodule : tb
